// ### src/operand_access_timing.sv
// operand addressing cycle, access and length accounting for a 16-bit core
`timescale 1ns/1ps
`include "operand_timing_regs.svh"
module operand_access_timing #(
	parameter int CW = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_req, // one-cycle request to account an instruction
	input wire logic [4:0] i_ea_code,
	input wire logic [CW-1:0] i_base_cycles, // base state count from instruction tables
	input wire logic [CW-1:0] i_reg_ea_cycles, // cycles for codes 00 to 07, from tables
	input wire logic [2:0] i_reg_ea_accesses,
	input wire logic [3:0] i_base_length,
	input wire operand_timing_pkg::opsize_t i_size,
	input wire operand_timing_pkg::oploc_t i_loc,
	input wire logic i_odd_addr,
	input wire logic i_fetch_ext16, // program fetch from 16-bit external bus
	input wire logic i_fetch_ext8,
	input wire logic i_fetch_word, // word-boundary fetch (else byte boundary)
	input wire logic i_ready, // external ready; low inserts waits
	input wire logic [1:0] i_auto_wait, // automatic ready wait count per access
	output logic o_busy,
	output logic o_done,
	output logic [CW-1:0] o_total_cycles,
	output logic [CW-1:0] o_worst_cycles,
	output logic [3:0] o_length,
	output logic [3:0] o_ea_cycles,
	output logic [2:0] o_reg_accesses,
	output logic [2:0] o_op_accesses
);
	import operand_timing_pkg::*;

	typedef struct packed {
		state_t st;
		logic done;
		logic ext;
		logic [2:0] acc_left;
		logic [1:0] auto_left;
		logic [CW-1:0] total;
		logic [CW-1:0] worst;
		logic [3:0] len;
		logic [3:0] eac;
		logic [2:0] rga;
		logic [2:0] opa;
	} regs_t;

	regs_t q, d;
	logic [3:0] ea_cyc, op_cyc, fetch_cyc;
	logic [2:0] ea_acc, op_acc;
	logic [1:0] ext_len;
	logic is_ext;

	// effective-address cycles, register accesses and extension length
	always_comb begin
		ea_cyc = 4'h0;
		ea_acc = 3'h0;
		ext_len = 2'h0;
		if (i_ea_code <= 5'h07) begin
			ea_cyc = 4'h0;
			ea_acc = i_reg_ea_accesses;
		end else if (i_ea_code <= `EA_IND_LAST) begin
			ea_cyc = `EA_CYC_SHORT;
			ea_acc = `EA_ACC_ONE;
		end else if (i_ea_code <= `EA_POSTINC_LAST) begin
			ea_cyc = `EA_CYC_LONG;
			ea_acc = `EA_ACC_TWO;
		end else if (i_ea_code <= `EA_OFF8_LAST) begin
			ea_cyc = `EA_CYC_SHORT;
			ea_acc = `EA_ACC_ONE;
			ext_len = `EXT_LEN_OFF8;
		end else if (i_ea_code <= `EA_OFF16_LAST) begin
			ea_cyc = `EA_CYC_SHORT;
			ea_acc = `EA_ACC_ONE;
			ext_len = `EXT_LEN_TWO;
		end else if (i_ea_code == `EA_IDX0 || i_ea_code == `EA_IDX1) begin
			ea_cyc = `EA_CYC_LONG;
			ea_acc = `EA_ACC_TWO;
		end else if (i_ea_code == `EA_PCREL) begin
			ea_cyc = `EA_CYC_SHORT;
			ext_len = `EXT_LEN_TWO;
		end else begin
			ea_cyc = `EA_CYC_DIRECT;
			ext_len = `EXT_LEN_TWO;
		end
	end

	// operand size and location correction
	always_comb begin
		op_cyc = 4'h0;
		op_acc = (i_size == SZ_LONG) ? `OP_ACC_TWO : `OP_ACC_ONE;
		is_ext = 1'b0;
		case (i_loc)
			LOC_INT: begin
				if (i_odd_addr && i_size == SZ_WORD) begin
					op_cyc = `OP_CYC_ODD_WORD;
					op_acc = `OP_ACC_TWO;
				end else if (i_odd_addr && i_size == SZ_LONG) begin
					op_cyc = `OP_CYC_ODD_LONG;
					op_acc = `OP_ACC_FOUR;
				end
			end
			LOC_EXT16, LOC_EXT8: begin
				is_ext = 1'b1;
				if (i_size == SZ_BYTE) begin
					op_cyc = `OP_CYC_EXT_ONE;
				end else if (i_loc == LOC_EXT16 && !i_odd_addr) begin
					op_cyc = (i_size == SZ_LONG) ? `OP_CYC_EXT_TWO : `OP_CYC_EXT_ONE;
				end else if (i_size == SZ_WORD) begin
					op_cyc = `OP_CYC_SLOW_WORD;
					op_acc = `OP_ACC_TWO;
				end else begin
					op_cyc = `OP_CYC_SLOW_LONG;
					op_acc = `OP_ACC_FOUR;
				end
			end
			default: begin
				op_cyc = 4'h0;
			end
		endcase
	end

	// worst-case program fetch correction
	always_comb begin
		fetch_cyc = 4'h0;
		if (i_fetch_ext8 && !i_fetch_word) begin
			fetch_cyc = `FETCH_EXT8_BYTE;
		end else if (i_fetch_ext16 && i_fetch_word) begin
			fetch_cyc = `FETCH_EXT16_WORD;
		end else if (!i_fetch_ext16 && !i_fetch_ext8 && i_fetch_word) begin
			fetch_cyc = `FETCH_INT_WORD;
		end
	end

	// accounting sequence: take request, then add wait cycles per external access
	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			ST_IDLE: begin
				if (i_req) begin
					d.total = i_base_cycles + CW'(ea_cyc) + CW'(op_cyc)
						+ ((i_ea_code <= 5'h07) ? i_reg_ea_cycles : '0);
					d.worst = i_base_cycles + CW'(ea_cyc) + CW'(op_cyc) + CW'(fetch_cyc)
						+ ((i_ea_code <= 5'h07) ? i_reg_ea_cycles : '0);
					d.len = i_base_length + {2'b00, ext_len};
					d.eac = ea_cyc;
					d.rga = ea_acc;
					d.opa = op_acc;
					d.ext = is_ext || i_fetch_ext16 || i_fetch_ext8;
					d.acc_left = is_ext ? op_acc : 3'h1;
					d.auto_left = i_auto_wait;
					if (is_ext || i_fetch_ext16 || i_fetch_ext8) begin
						d.st = ST_WAIT;
					end else begin
						d.done = 1'b1;
					end
				end
			end
			default: begin
				// each external access stretched by automatic waits then ready-low waits
				if (q.auto_left != 2'h0) begin
					d.auto_left = q.auto_left - 2'h1;
					d.total = q.total + CW'(1);
					d.worst = q.worst + CW'(1);
				end else if (!i_ready) begin
					d.total = q.total + CW'(1);
					d.worst = q.worst + CW'(1);
				end else if (q.acc_left > 3'h1) begin
					d.acc_left = q.acc_left - 3'h1;
					d.auto_left = i_auto_wait;
				end else begin
					d.st = ST_IDLE;
					d.done = 1'b1;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			q <= '{st: ST_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign o_busy = (q.st == ST_WAIT);
	assign o_done = q.done;
	assign o_total_cycles = q.total;
	assign o_worst_cycles = q.worst;
	assign o_length = q.len;
	assign o_ea_cycles = q.eac;
	assign o_reg_accesses = q.rga;
	assign o_op_accesses = q.opa;

	// checks
	direct_ea_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_ea_code == 5'h1f) |=> (o_ea_cycles == 4'h1 && o_reg_accesses == 3'h0))
		else $error("direct ea accounting wrong");
	postinc_ea_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_ea_code inside {[5'h0c:5'h0f]}) |=> (o_ea_cycles == 4'h4 && o_reg_accesses == 3'h2))
		else $error("post-increment accounting wrong");
	pcrel_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_ea_code == 5'h1e) |=> (o_length == $past(i_base_length) + 4'h2))
		else $error("pc-relative length wrong");
	odd_long_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_loc == LOC_INT && i_odd_addr && i_size == SZ_LONG) |=> o_op_accesses == 3'h4)
		else $error("odd internal long accesses wrong");
	reg_long_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_loc == LOC_REG && i_size == SZ_LONG) |=> o_op_accesses == 3'h2)
		else $error("register long accesses wrong");
	ext8_word_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_loc == LOC_EXT8 && i_size == SZ_WORD) |=> o_op_accesses == 3'h2)
		else $error("8-bit bus word accesses wrong");
	ready_wait_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_busy && q.auto_left == 2'h0 && !i_ready) |=> (o_busy && o_total_cycles == $past(o_total_cycles) + CW'(1)))
		else $error("ready wait not counted");
	worst_bound_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_done |-> (o_worst_cycles >= o_total_cycles
			&& o_worst_cycles - o_total_cycles <= CW'(`FETCH_EXT16_WORD)))
		else $error("worst case below total");
	internal_done_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(q.st == ST_IDLE && i_req && i_loc == LOC_INT && !i_fetch_ext8 && !i_fetch_ext16) |=> o_done)
		else $error("internal accounting not done in one cycle");
	wait_cover: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_busy && !i_ready);
	ext_long_cover: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_req && i_loc == LOC_EXT16 && i_size == SZ_LONG);
	done_cover: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_done);
endmodule : operand_access_timing

// ### inc/operand_timing_regs.svh
// timing and encoding constants for operand access cycle accounting
`ifndef OPERAND_TIMING_REGS_SVH
`define OPERAND_TIMING_REGS_SVH
`define EA_IND_LAST 5'h0b
`define EA_POSTINC_LAST 5'h0f
`define EA_OFF8_LAST 5'h17
`define EA_OFF16_LAST 5'h1b
`define EA_IDX0 5'h1c
`define EA_IDX1 5'h1d
`define EA_PCREL 5'h1e
`define EA_DIRECT 5'h1f
`define EA_CYC_SHORT 4'h2
`define EA_CYC_LONG 4'h4
`define EA_CYC_DIRECT 4'h1
`define EA_ACC_ONE 3'h1
`define EA_ACC_TWO 3'h2
`define EXT_LEN_OFF8 2'h1
`define EXT_LEN_TWO 2'h2
`define OP_ACC_ONE 3'h1
`define OP_ACC_TWO 3'h2
`define OP_ACC_FOUR 3'h4
`define OP_CYC_ODD_WORD 4'h2
`define OP_CYC_ODD_LONG 4'h4
`define OP_CYC_EXT_ONE 4'h1
`define OP_CYC_EXT_TWO 4'h2
`define OP_CYC_SLOW_WORD 4'h4
`define OP_CYC_SLOW_LONG 4'h8
`define FETCH_INT_WORD 4'h2
`define FETCH_EXT16_WORD 4'h3
`define FETCH_EXT8_BYTE 4'h3
`endif

// ### inc/operand_timing_pkg.sv
// types for operand access cycle accounting
package operand_timing_pkg;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} opsize_t;
	typedef enum logic [2:0] {LOC_REG, LOC_INT, LOC_EXT16, LOC_EXT8} oploc_t;
	typedef enum logic {ST_IDLE, ST_WAIT} state_t;
endpackage : operand_timing_pkg

// ### dv/ext_bus_model.sv
// model of a slow device on the external data bus that inserts ready waits
`timescale 1ns/1ps
module ext_bus_model (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_busy, // an access is open while accounting runs
	input wire logic [1:0] i_stall, // ready-low cycles per access
	output logic o_ready
);
	logic [1:0] cnt_q;
	// hold ready low for the stall count, then release it for one cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || !i_busy || o_ready) cnt_q <= 2'h0;
		else cnt_q <= cnt_q + 2'h1;
	end
	assign o_ready = (cnt_q == i_stall);
endmodule : ext_bus_model

// ### dv/operand_access_timing_tb.sv
// self-checking bench for operand addressing cycle accounting
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp=%0d got=%0d", nm, e, g); end end
module operand_access_timing_tb;
	import operand_timing_pkg::*;
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_odd_addr = 1'b0;
	logic i_fetch_ext16 = 1'b0, i_fetch_ext8 = 1'b0, i_fetch_word = 1'b0, ready;
	logic [4:0] i_ea_code = 5'h00;
	logic [1:0] i_auto_wait = 2'h0, stall = 2'h0;
	opsize_t i_size = SZ_BYTE;
	oploc_t i_loc = LOC_REG;
	logic busy, done;
	logic [7:0] tot_o, worst_o;
	logic [3:0] len_o, eac_o;
	logic [2:0] rac_o, acc_o;
	int failures = 0, num_checks = 0, cycles = 0;
	operand_access_timing #(.CW(8)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
		.i_ea_code(i_ea_code), .i_base_cycles(8'h0a), .i_reg_ea_cycles(8'h03),
		.i_reg_ea_accesses(3'h1), .i_base_length(4'h4), .i_size(i_size), .i_loc(i_loc),
		.i_odd_addr(i_odd_addr), .i_fetch_ext16(i_fetch_ext16), .i_fetch_ext8(i_fetch_ext8),
		.i_fetch_word(i_fetch_word), .i_ready(ready), .i_auto_wait(i_auto_wait), .o_busy(busy),
		.o_done(done), .o_total_cycles(tot_o), .o_worst_cycles(worst_o), .o_length(len_o),
		.o_ea_cycles(eac_o), .o_reg_accesses(rac_o), .o_op_accesses(acc_o));
	ext_bus_model bus_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_busy(busy), .i_stall(stall),
		.o_ready(ready));
	// clock and hang guard
	initial forever #2 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end
	// drive one request and wait for its completion pulse
	task automatic run(input int c, s, l, odd, f16, f8, fw, aw);
		@(posedge i_mclk);
		i_req <= 1'b1;
		i_ea_code <= c[4:0];
		i_size <= opsize_t'(s);
		i_loc <= oploc_t'(l);
		i_odd_addr <= odd[0];
		i_fetch_ext16 <= f16[0];
		i_fetch_ext8 <= f8[0];
		i_fetch_word <= fw[0];
		i_auto_wait <= aw[1:0];
		@(posedge i_mclk);
		i_req <= 1'b0;
		for (int k = 0; k < 200; k++) begin
			@(negedge i_mclk);
			if (k == 0) `CHK("busy", (l >= 2 || (f16 | f8) != 0) ? 1 : 0, busy)
			if (done === 1'b1) break;
		end
		`CHK("done", 1, done)
		`CHK("idle", 0, busy)
	endtask : run
	// run a request and compare every result with the reckoned figures
	task automatic run_chk(input int c, s, l, odd, f16, f8, fw, aw);
		int ec, rc, ln, acc, oc, nacc, fc, tot;
		ec = c < 8 ? 0 : c < 12 ? 2 : c < 16 ? 4 : c < 28 ? 2 : c < 30 ? 4 : c == 30 ? 2 : 1;
		rc = c < 8 ? 1 : c < 12 ? 1 : c < 16 ? 2 : c < 28 ? 1 : c < 30 ? 2 : 0;
		ln = c < 16 ? 0 : c < 24 ? 1 : c < 28 ? 2 : c < 30 ? 0 : 2;
		acc = (l == 3 || (odd != 0 && l != 0)) ? (1 << s) : (s == 2 ? 2 : 1);
		oc = l == 0 ? 0 : l == 1 ? (odd != 0 ? 2 * s : 0) : (l == 3 || odd != 0) ? (s == 0 ? 1 : 4 * s) : acc;
		nacc = l >= 2 ? acc : (f16 | f8) != 0 ? 1 : 0;
		fc = f16 != 0 ? (fw != 0 ? 3 : 0) : f8 != 0 ? (fw != 0 ? 0 : 3) : (fw != 0 ? 2 : 0);
		tot = 10 + (c < 8 ? 3 : ec) + oc + nacc * aw;
		run(c, s, l, odd, f16, f8, fw, aw);
		`CHK("ea_cycles", ec, eac_o)
		`CHK("reg_accesses", rc, rac_o)
		`CHK("length", 4 + ln, len_o)
		`CHK("op_accesses", acc, acc_o)
		`CHK("total", tot, tot_o)
		`CHK("worst", tot + fc, worst_o)
	endtask : run_chk
	// every addressing code with a register operand
	task automatic t_codes();
		for (int c = 0; c < 32; c++) run_chk(c, 0, 0, 0, 0, 0, 0, 0);
		$display("test codes done");
	endtask : t_codes
	// every location, size and alignment through direct addressing
	task automatic t_locs();
		for (int l = 0; l < 4; l++)
			for (int s = 0; s < 3; s++)
				for (int o = 0; o < 2; o++) run_chk(31, s, l, o, 0, 0, 0, 0);
		$display("test locations done");
	endtask : t_locs
	// fetch corrections for each bus and boundary
	task automatic t_fetch();
		for (int f = 0; f < 3; f++)
			for (int w = 0; w < 2; w++) run_chk(8, 1, 1, 0, f == 1, f == 2, w, 0);
		$display("test fetch done");
	endtask : t_fetch
	// automatic waits per access, then a slow device holding ready low
	task automatic t_waits();
		run_chk(16, 0, 3, 0, 0, 0, 0, 1);
		run_chk(16, 2, 2, 1, 0, 0, 0, 2);
		run_chk(17, 1, 2, 0, 1, 0, 1, 3);
		run_chk(9, 0, 1, 0, 0, 1, 0, 2);
		stall = 2'h2;
		run(31, 2, 3, 0, 0, 0, 0, 0);
		`CHK("slow_total", 27, tot_o)
		`CHK("slow_worst", 27, worst_o)
		stall = 2'h0;
		$display("test waits done");
	endtask : t_waits
	// verdict
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_codes();
		t_locs();
		t_fetch();
		t_waits();
		conclude();
	end
endmodule : operand_access_timing_tb
